//--- scp_pkg.sv
// constants and types of the serial configuration port
// assumes one system clock; link pins are sampled, never used as clocks
package scp_pkg;
	localparam int ADDR_W    = 5;
	localparam int BYTE_W    = 8;
	localparam int IDX_W     = 3;
	localparam int RNW_BIT   = 7;
	localparam int CTRL_BIT  = 7;
	localparam int CLK_NS    = 40;
	localparam int SCLK_MIN_NS = 40;
	// link clock is sampled: one half period must span this many cycles
	localparam int SCLK_HALF_CYC = (SCLK_MIN_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
	localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
	localparam logic [4:0] ADDR_RISE_DLT = 5'h02;
	localparam logic [4:0] ADDR_FALL_DLT = 5'h03;
	localparam logic [4:0] ADDR_RISE_RT  = 5'h04;
	localparam logic [4:0] ADDR_FALL_RT  = 5'h05;
	localparam logic [2:0] BYTES_CTRL   = 3'h4;
	localparam logic [2:0] BYTES_DELTA  = 3'h3;
	localparam logic [2:0] BYTES_RATE   = 3'h2;
	localparam logic [2:0] BYTES_TUNING = 3'h6;
	// byte lane of control_word_one holding each port control bit
	localparam logic [2:0] LANE_LSB_FIRST  = 3'h1;
	localparam logic [2:0] LANE_INPUT_ONLY = 3'h0;
	localparam logic LSB_FIRST_RST  = 1'b0;
	localparam logic INPUT_ONLY_RST = 1'b0;

	typedef enum logic [1:0] {
		PH_INSTR = 2'b01,
		PH_DATA  = 2'b10
	} scp_phase_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [IDX_W-1:0]  idx;
		logic [BYTE_W-1:0] data;
	} scp_wr_type;

	function automatic logic [2:0] scp_byte_count(input logic [4:0] a);
		case (a)
			ADDR_CTRL_ONE, ADDR_CTRL_TWO: scp_byte_count = BYTES_CTRL;
			ADDR_RISE_DLT, ADDR_FALL_DLT: scp_byte_count = BYTES_DELTA;
			ADDR_RISE_RT, ADDR_FALL_RT:   scp_byte_count = BYTES_RATE;
			default:                      scp_byte_count = BYTES_TUNING;
		endcase
	endfunction : scp_byte_count
endpackage : scp_pkg

//--- scp_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes the same clock and synchronous reset as its user
`timescale 1ns/1ns
module scp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// drain side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} scp_fifo_state_type;
	scp_fifo_state_type q, d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full, empty, doWr;

	assign full     = (q.wrPtr[AW-1:0] == q.rdPtr[AW-1:0]) && (q.wrPtr[AW] != q.rdPtr[AW]);
	assign empty    = q.wrPtr == q.rdPtr;
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[q.rdPtr[AW-1:0]];
	assign doWr     = inValid && !full;

	always_comb begin
		d = q;
		if (doWr) begin
			d.wrPtr = q.wrPtr + 1'b1;
		end
		if (outReady && !empty) begin
			d.rdPtr = q.rdPtr + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
		if (doWr) begin
			mem[q.wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule : scp_fifo

//--- scp_port.sv
// serial configuration port: instruction byte, then register data bytes
// assumes link pins are asynchronous and sampled; link clock well below clock/2
// Contract
// R1: first eight rising link edges of a cycle carry the instruction byte
// R2: data phase moves as many bytes as the addressed register is wide
// R3: after the last data byte the next eight edges are a new instruction
// R4: input bits are captured on rising link clock edges
// R5: read data changes on falling link clock edges
// R6: instruction bit seven set means read, clear means write
// R7: instruction bits six and five are ignored
// R8: instruction bits four to zero address the register
// R9: select high puts both data outputs in high impedance
// R10: select high mid-cycle pauses it; cycle resumes at same point
// R11: controller may hold select low only if it owns the link clock
// R12: input-only bit at reset zero makes the data pin bidirectional
// R13: separate-line mode reads on the output pin, otherwise it stays undriven
// R14: port reset aborts the cycle, keeps control bits, restarts at instruction
// R15: controller holds port reset low when unused
// R16: bit-order control resets to msb first; set means lsb first
// R17: controller sends the instruction byte in the selected bit order
// R18: every data byte follows the selected bit order
// R19: controller keeps the link clock at or below its maximum rate
// R20: bidirectional pin is driven only in the data phase of a read
`timescale 1ns/1ns
module scp_port
	import scp_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// serial link pins
	input  wire logic              serialClock,
	input  wire logic              selectN,
	input  wire logic              portReset,
	input  wire logic              serialDataIoIn,
	output logic                   serialDataIoOut,
	output logic                   serialDataIoOe,
	output logic                   serialDataOutOut,
	output logic                   serialDataOutOe,
	// read data source
	output logic [ADDR_W-1:0]      rdAddr,
	output logic [IDX_W-1:0]       rdIdx,
	input  wire logic [BYTE_W-1:0] rdByte,
	// written bytes
	output logic                   wrValid,
	output scp_wr_type             wrData,
	input  wire logic              wrReady,
	// status
	output logic                   lsbFirst,
	output logic                   inputOnly,
	output logic                   wrOverrun
);
	typedef struct packed {
		logic [2:0]        sclkSync;
		logic [1:0]        selSync;
		logic [1:0]        dinSync;
		logic [1:0]        abortSync;
		scp_phase_type     phase;
		logic              rnw;
		logic [ADDR_W-1:0] addr;
		logic [2:0]        bitCnt;
		logic [IDX_W-1:0]  byteIdx;
		logic [IDX_W-1:0]  nBytes;
		logic [BYTE_W-1:0] rxSh;
		logic [BYTE_W-1:0] txSh;
		logic              drv;
		logic              lsbFirst;
		logic              inOnly;
		logic              pendLsb;
		logic              pendIn;
		logic              sdioOut;
		logic              sdioOe;
		logic              sdoOut;
		logic              sdoOe;
		logic              overrun;
	} scp_state_type;

	scp_state_type q, d;
	logic              selHigh, abort, rise, fall, bitIn;
	logic              lastBit, lastByte, push, pushReady;
	logic [BYTE_W-1:0] rxNext;
	scp_wr_type        pushWord;

	assign selHigh  = q.selSync[1];
	assign abort    = q.abortSync[1];
	assign bitIn    = q.dinSync[1];
	// edges are found on the second and third sample, never the first
	assign rise     = q.sclkSync[1] && !q.sclkSync[2] && !selHigh; // R4 R10
	assign fall     = !q.sclkSync[1] && q.sclkSync[2] && !selHigh; // R5 R10
	assign rxNext   = q.lsbFirst ? {bitIn, q.rxSh[7:1]} : {q.rxSh[6:0], bitIn}; // R17 R18
	assign lastBit  = q.bitCnt == 3'h7;
	assign lastByte = q.byteIdx == q.nBytes - 3'h1;
	assign pushWord = '{addr: q.addr, idx: q.byteIdx, data: rxNext};

	always_comb begin
		logic [IDX_W-1:0]  lane;
		logic [BYTE_W-1:0] tx;
		logic              pl, pi;
		lane = '0;
		tx   = '0;
		pl   = q.pendLsb;
		pi   = q.pendIn;
		push = 1'b0;
		d    = q;
		d.sclkSync  = {q.sclkSync[1:0], serialClock};
		d.selSync   = {q.selSync[0], selectN};
		d.dinSync   = {q.dinSync[0], serialDataIoIn};
		d.abortSync = {q.abortSync[0], portReset};
		if (abort) begin
			// control bits survive a port reset
			d.phase   = PH_INSTR; // R14
			d.bitCnt  = '0;
			d.byteIdx = '0;
			d.drv     = 1'b0;
		end else begin
			if (rise) begin
				d.bitCnt = q.bitCnt + 3'h1;
				d.rxSh   = rxNext; // R4
				if (q.phase == PH_INSTR && lastBit) begin
					d.phase   = PH_DATA; // R1
					d.rnw     = rxNext[RNW_BIT]; // R6
					d.addr    = rxNext[ADDR_W-1:0]; // R7 R8
					d.nBytes  = scp_byte_count(rxNext[ADDR_W-1:0]); // R2
					d.byteIdx = '0;
					d.pendLsb = q.lsbFirst;
					d.pendIn  = q.inOnly;
				end else if (q.phase == PH_DATA && lastBit) begin
					if (!q.rnw) begin
						push = 1'b1;
						lane = q.lsbFirst ? q.byteIdx : q.nBytes - 3'h1 - q.byteIdx; // R18
						if (q.addr == ADDR_CTRL_ONE && lane == LANE_LSB_FIRST) begin
							pl = rxNext[CTRL_BIT]; // R16
						end
						if (q.addr == ADDR_CTRL_ONE && lane == LANE_INPUT_ONLY) begin
							pi = rxNext[CTRL_BIT]; // R12
						end
					end
					d.pendLsb = pl;
					d.pendIn  = pi;
					if (lastByte) begin
						d.phase = PH_INSTR; // R3
						d.drv   = 1'b0;
						if (!q.rnw) begin
							d.lsbFirst = pl;
							d.inOnly   = pi;
						end
					end else begin
						d.byteIdx = q.byteIdx + 3'h1; // R2
					end
				end
			end
			if (fall && q.phase == PH_DATA && q.rnw) begin
				tx = (q.bitCnt == 3'h0) ? rdByte : q.txSh;
				d.txSh    = q.lsbFirst ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0}; // R18
				d.sdioOut = q.lsbFirst ? tx[0] : tx[7]; // R5
				d.sdoOut  = q.lsbFirst ? tx[0] : tx[7]; // R5
				d.drv     = 1'b1; // R20
			end
		end
		d.sdioOe = !selHigh && d.drv && !q.inOnly; // R9 R12 R20
		d.sdoOe  = !selHigh && d.drv && q.inOnly; // R9 R13
		if (push && !pushReady) begin
			d.overrun = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q          <= '0;
			q.sclkSync <= 3'h0;
			q.selSync  <= 2'h3;
			q.phase    <= PH_INSTR;
			q.nBytes   <= BYTES_CTRL;
			q.lsbFirst <= LSB_FIRST_RST;
			q.inOnly   <= INPUT_ONLY_RST;
			q.pendLsb  <= LSB_FIRST_RST;
			q.pendIn   <= INPUT_ONLY_RST;
		end else begin
			q <= d;
		end
	end

	scp_fifo #(
		.WIDTH ($bits(scp_wr_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.rst      (rst),
		.inValid  (push),
		.inData   (pushWord),
		.inReady  (pushReady),
		.outValid (wrValid),
		.outData  (wrData),
		.outReady (wrReady)
	);

	assign serialDataIoOut  = q.sdioOut;
	assign serialDataIoOe   = q.sdioOe;
	assign serialDataOutOut = q.sdoOut;
	assign serialDataOutOe  = q.sdoOe;
	assign rdAddr           = q.addr;
	assign rdIdx            = q.byteIdx;
	assign lsbFirst         = q.lsbFirst;
	assign inputOnly        = q.inOnly;
	assign wrOverrun        = q.overrun;

	a_select_hiz: assert property (@(posedge clock) disable iff (rst) // R9
		selHigh |=> !serialDataIoOe && !serialDataOutOe)
		else $error("data output driven while select high");

	a_instr_len: assert property (@(posedge clock) disable iff (rst) // R1
		(q.phase == PH_INSTR && rise && lastBit && !abort) |=> q.phase == PH_DATA)
		else $error("instruction byte not closed after eight edges");

	a_cycle_end: assert property (@(posedge clock) disable iff (rst) // R3
		(q.phase == PH_DATA && rise && lastBit && lastByte && !abort)
		|=> q.phase == PH_INSTR && q.bitCnt == 3'h0)
		else $error("cycle not ended after last data byte");

	a_abort_port: assert property (@(posedge clock) disable iff (rst) // R14
		abort |=> q.phase == PH_INSTR && q.bitCnt == 3'h0 && $stable(q.lsbFirst))
		else $error("port reset did not restart cycle");

	a_pause_hold: assert property (@(posedge clock) disable iff (rst) // R10
		(selHigh && !abort) |=> $stable(q.bitCnt) && $stable(q.byteIdx) && $stable(q.phase))
		else $error("cycle advanced while select high");

	a_fall_change: assert property (@(posedge clock) disable iff (rst) // R5
		$changed(q.sdioOut) |-> $past(fall))
		else $error("read data changed off a falling edge");

	a_drive_read: assert property (@(posedge clock) disable iff (rst) // R20
		serialDataIoOe |-> $past(q.rnw && q.phase == PH_DATA && !q.inOnly))
		else $error("data pin driven outside a read data phase");

	a_sdo_quiet: assert property (@(posedge clock) disable iff (rst) // R13
		(!q.inOnly && !$past(q.inOnly)) |-> !serialDataOutOe)
		else $error("output pin driven in bidirectional mode");

	a_write_push: assert property (@(posedge clock) disable iff (rst) // R2
		(q.phase == PH_DATA && !q.rnw && rise && lastBit && !abort) |-> push)
		else $error("written byte not passed on");

	a_sdo_read: assert property (@(posedge clock) disable iff (rst) // R13
		serialDataOutOe |-> $past(q.rnw && q.phase == PH_DATA && q.inOnly))
		else $error("output pin driven outside a read data phase");

	a_sdo_fall: assert property (@(posedge clock) disable iff (rst) // R5
		$changed(q.sdoOut) |-> $past(fall))
		else $error("output pin changed off a falling edge");

	a_rx_rise: assert property (@(posedge clock) disable iff (rst) // R4
		$changed(q.rxSh) |-> $past(rise))
		else $error("input captured off a rising edge");

	a_lsb_instr: assert property (@(posedge clock) disable iff (rst) // R6 R17
		(q.phase == PH_INSTR && rise && lastBit && !abort && q.lsbFirst)
		|=> q.rnw == $past(bitIn))
		else $error("direction not taken from the last instruction bit");

	a_msb_instr: assert property (@(posedge clock) disable iff (rst) // R6 R17
		(q.phase == PH_INSTR && rise && lastBit && !abort && !q.lsbFirst)
		|=> q.rnw == $past(q.rxSh[6]))
		else $error("direction not taken from the first instruction bit");

	a_addr_take: assert property (@(posedge clock) disable iff (rst) // R7 R8
		(q.phase == PH_INSTR && rise && lastBit && !abort)
		|=> q.addr == $past(rxNext[ADDR_W-1:0]))
		else $error("address not taken from the low instruction bits");

	a_ctrl_len: assert property (@(posedge clock) disable iff (rst) // R2
		(q.phase == PH_INSTR && rise && lastBit && !abort
			&& rxNext[ADDR_W-1:0] == ADDR_CTRL_TWO) |=> q.nBytes == BYTES_CTRL)
		else $error("control word length wrong");

	a_tuning_len: assert property (@(posedge clock) disable iff (rst) // R2
		(q.phase == PH_INSTR && rise && lastBit && !abort
			&& rxNext[ADDR_W-1:0] > ADDR_FALL_RT) |=> q.nBytes == BYTES_TUNING)
		else $error("tuning word length wrong");

	a_order_set: assert property (@(posedge clock) disable iff (rst) // R16
		$changed(q.lsbFirst) |-> $past(q.phase == PH_DATA && !q.rnw && q.addr == ADDR_CTRL_ONE
			&& rise && lastBit && lastByte && !abort))
		else $error("bit order changed outside a control word write");

	a_pin_set: assert property (@(posedge clock) disable iff (rst) // R12
		$changed(q.inOnly) |-> $past(q.phase == PH_DATA && !q.rnw && q.addr == ADDR_CTRL_ONE
			&& rise && lastBit && lastByte && !abort))
		else $error("pin arrangement changed outside a control word write");

	a_idle_quiet: assert property (@(posedge clock) disable iff (rst) // R20
		(q.phase == PH_INSTR && $past(q.phase == PH_INSTR))
		|-> !serialDataIoOe && !serialDataOutOe)
		else $error("data output driven during the instruction byte");

	a_abort_quiet: assert property (@(posedge clock) disable iff (rst) // R14
		abort |=> !serialDataIoOe && !serialDataOutOe)
		else $error("data output driven after a port reset");

	a_pause_keep: assert property (@(posedge clock) disable iff (rst) // R10
		(selHigh && !abort) |=> $stable(q.rxSh) && $stable(q.txSh) && $stable(q.addr))
		else $error("shift state moved while select high");

	a_drop_flag: assert property (@(posedge clock) disable iff (rst) // R2
		(push && !pushReady) |=> wrOverrun)
		else $error("dropped byte not flagged");

	a_read_msb: assert property (@(posedge clock) disable iff (rst) // R5 R18
		(fall && q.phase == PH_DATA && q.rnw && q.bitCnt == 3'h0 && !abort && !q.lsbFirst)
		|=> serialDataIoOut == $past(rdByte[7]) && serialDataOutOut == $past(rdByte[7]))
		else $error("read byte not started at its top bit");

	a_read_lsb: assert property (@(posedge clock) disable iff (rst) // R5 R18
		(fall && q.phase == PH_DATA && q.rnw && q.bitCnt == 3'h0 && !abort && q.lsbFirst)
		|=> serialDataIoOut == $past(rdByte[0]) && serialDataOutOut == $past(rdByte[0]))
		else $error("read byte not started at its bottom bit");
endmodule : scp_port

//--- scp_ctrl_model.sv
// controller model that drives the serial configuration link
// assumes the bench resolves the data wire and returns it on dataIn
`timescale 1ns/1ns
module scp_ctrl_model (
	// clock
	input  wire logic clock,
	// link pins
	output logic      serialClock = 1'b0,
	output logic      selectN     = 1'b1,
	output logic      portReset   = 1'b0,
	output logic      ctrlData    = 1'b0,
	output logic      ctrlOe      = 1'b1,
	output logic      rdPhase     = 1'b0,
	input  wire logic dataIn
);
	// a released line shows a toggling pattern, never a held value
	always @(negedge clock) if (!ctrlOe) ctrlData <= ~ctrlData;
	task automatic tick(input int c);
		repeat (c) @(negedge clock);
	endtask : tick
	// four-cycle half period keeps the link well below its rate limit
	task automatic frame(input logic [7:0] ins, input int n, input logic [47:0] w,
		input logic lsb, input int brk, input logic abrt, output logic [47:0] r);
		int j;
		r = '0;
		selectN = 1'b0;
		tick(4);
		for (int i = 0; i < 8 + 8 * n; i++) begin
			j = i - 8;
			if (i == brk && abrt) begin
				portReset = 1'b1;
				tick(4);
				portReset = 1'b0;
				tick(4);
				break;
			end
			if (i == brk) begin
				selectN = 1'b1;
				tick(4);
				repeat (2) begin
					serialClock = ~serialClock;
					tick(4);
				end
				selectN = 1'b0;
				tick(4);
			end
			if (i == 8 && ins[7]) begin
				rdPhase = 1'b1;
				ctrlOe = 1'b0;
			end
			if (i < 8) ctrlData = lsb ? ins[i] : ins[7 - i];
			else if (ctrlOe) ctrlData = lsb ? w[j] : w[8 * n - 1 - j];
			tick(4);
			serialClock = 1'b1;
			tick(1);
			if (!ctrlOe) r[lsb ? j : 8 * n - 1 - j] = dataIn;
			tick(3);
			serialClock = 1'b0;
		end
		tick(4);
		selectN = 1'b1;
		tick(6);
		rdPhase = 1'b0;
		ctrlOe = 1'b1;
	endtask : frame
endmodule : scp_ctrl_model

//--- serial_config_port_tb_top.sv
// self-checking bench of the serial configuration port
// assumes scp_ctrl_model drives the link and scp_pkg is compiled first
`timescale 1ns/1ns
module serial_config_port_tb_top
	import scp_pkg::*;
;
	logic              clock, rst, wrReady, stall, sepMode, ioWire, outWire;
	logic              serialClock, selectN, portReset, ctrlData, ctrlOe, rdPhase;
	logic              serialDataIoOut, serialDataIoOe, serialDataOutOut, serialDataOutOe;
	logic              wrValid, lsbFirst, inputOnly, wrOverrun;
	logic [ADDR_W-1:0] rdAddr;
	logic [IDX_W-1:0]  rdIdx;
	logic [BYTE_W-1:0] rdByte;
	logic [31:0]       seed;
	int                numErrors, cmpCount;
	scp_wr_type        wrData;
	scp_wr_type        exp[$];
	assign ioWire  = serialDataIoOe ? serialDataIoOut : ctrlData;
	assign outWire = serialDataOutOe ? serialDataOutOut : ~ctrlData;
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	scp_port #(.FIFO_DEPTH(8)) i_scp_port (
		.clock(clock), .rst(rst), .serialClock(serialClock), .selectN(selectN),
		.portReset(portReset), .serialDataIoIn(ioWire), .serialDataIoOut(serialDataIoOut),
		.serialDataIoOe(serialDataIoOe), .serialDataOutOut(serialDataOutOut),
		.serialDataOutOe(serialDataOutOe), .rdAddr(rdAddr), .rdIdx(rdIdx), .rdByte(rdByte),
		.wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .lsbFirst(lsbFirst),
		.inputOnly(inputOnly), .wrOverrun(wrOverrun));
	scp_ctrl_model i_scp_ctrl_model (
		.clock(clock), .serialClock(serialClock), .selectN(selectN), .portReset(portReset),
		.ctrlData(ctrlData), .ctrlOe(ctrlOe), .rdPhase(rdPhase),
		.dataIn(sepMode ? outWire : ioWire));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic int nb(input logic [4:0] a);
		if (a < 5'h02) return int'(BYTES_CTRL);
		if (a < 5'h04) return int'(BYTES_DELTA);
		if (a < 5'h06) return int'(BYTES_RATE);
		return int'(BYTES_TUNING);
	endfunction : nb
	task automatic tally(input logic bad, input logic [47:0] a, input logic [47:0] e);
		cmpCount++;
		if (bad) begin
			numErrors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, a, e);
		end
	endtask : tally
	task automatic cmpBit(input logic a, input logic e);
		tally(a !== e, 48'(a), 48'(e));
	endtask : cmpBit
	task automatic cmpWr(input scp_wr_type a, input scp_wr_type e);
		tally(a !== e, 48'(a), 48'(e));
	endtask : cmpWr
	task automatic cmpWord(input logic [47:0] a, input logic [47:0] e);
		tally(a !== e, a, e);
	endtask : cmpWord
	task automatic wr(input logic [7:0] ins, input logic [47:0] w, input logic lsb,
		input int brk, input logic abrt);
		logic [47:0] r;
		int n;
		n = nb(ins[4:0]);
		for (int k = 0; k < n && !abrt; k++)
			exp.push_back({ins[4:0], 3'(k), lsb ? w[k * 8 +: 8] : w[(n - 1 - k) * 8 +: 8]});
		i_scp_ctrl_model.frame(ins, n, w, lsb, brk, abrt, r);
	endtask : wr
	task automatic rd(input logic [7:0] ins, input logic lsb);
		logic [47:0] r;
		logic [47:0] e;
		int n;
		n = nb(ins[4:0]);
		e = '0;
		for (int k = 0; k < n; k++)
			e[(lsb ? k : n - 1 - k) * 8 +: 8] = {ins[4:0], 3'(k)} ^ 8'h5a;
		i_scp_ctrl_model.frame(ins, n, '0, lsb, -1, 1'b0, r);
		cmpWord(r, e);
	endtask : rd
	task automatic conclude;
		if (numErrors == 0 && cmpCount > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	always @(posedge clock) begin
		if (!rst && wrValid === 1'b1 && wrReady) begin
			if (exp.size() == 0) tally(1'b1, 48'(wrData), '0);
			else cmpWr(wrData, exp.pop_front());
		end
	end
	always @(negedge clock) begin
		seed <= lfsr(seed);
		wrReady <= !stall && seed[2];
		rdByte <= {rdAddr, rdIdx} ^ 8'h5a;
		if (!rst) begin
			cmpBit(serialDataIoOe & ~(rdPhase & ~sepMode), 1'b0);
			cmpBit(serialDataOutOe & ~(rdPhase & sepMode), 1'b0);
		end
	end
	initial begin
		repeat (60000) @(negedge clock);
		tally(1'b1, '0, '0);
		conclude();
	end
	initial begin
		rst = 1'b1;
		seed = 32'h1ea2;
		wrReady = 1'b0;
		rdByte = '0;
		stall = 1'b0;
		sepMode = 1'b0;
		numErrors = 0;
		cmpCount = 0;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		repeat (6) @(negedge clock);
		cmpBit(lsbFirst, LSB_FIRST_RST);
		cmpBit(inputOnly, INPUT_ONLY_RST);
		wr(8'h62, {seed[15:0], seed}, 1'b0, -1, 1'b0);
		wr(8'h09, {seed[15:0], seed}, 1'b0, 30, 1'b0);
		wr(8'h04, {seed[15:0], seed}, 1'b0, 5, 1'b1);
		wr(8'h05, {seed[15:0], seed}, 1'b0, -1, 1'b0);
		rd(8'h81, 1'b0);
		wr(8'h00, 48'h8080, 1'b0, -1, 1'b0);
		cmpBit(lsbFirst, 1'b1);
		cmpBit(inputOnly, 1'b1);
		sepMode = 1'b1;
		wr(8'h03, {seed[15:0], seed}, 1'b1, -1, 1'b0);
		rd(8'ha3, 1'b1);
		stall = 1'b1;
		wr(8'h0b, {seed[15:0], seed}, 1'b1, -1, 1'b0);
		wr(8'h02, {seed[15:0], seed}, 1'b1, -1, 1'b0);
		void'(exp.pop_back());
		cmpBit(wrOverrun, 1'b1);
		stall = 1'b0;
		for (int i = 0; i <= 400; i++) begin
			if (exp.size() == 0 && wrValid === 1'b0) break;
			if (i == 400) tally(1'b1, '0, '0);
			@(negedge clock);
		end
		conclude();
	end
endmodule : serial_config_port_tb_top
